/* common/oag_defines.svh */
// Functional notes
// - file direct: address from instruction field
// - indirect: address is base pointer unchanged
// - post-modify: use pointer, then step it
// - pre-modify: add signed step, use result
// - indexed: base pointer plus offset register
// - literal offset: base pointer plus literal
// - move/accumulator class also accepts indexed
// - move: two modes, one shared offset field
// - eight/nine to X, ten/eleven to Y
// - prefetch indexed only on nine and eleven
// - prefetch: indirect, indexed, post-modify 2/4/6
// - branch target is signed 16-bit literal
// - interrupt disable takes unsigned 14-bit literal
// - implied operands from opcode; no-op none
`ifndef OAG_DEFINES_SVH
`define OAG_DEFINES_SVH
`define OAG_NREGS        16
`define OAG_X_PTR_A      4'h8
`define OAG_X_PTR_B      4'h9
`define OAG_Y_PTR_A      4'hA
`define OAG_Y_PTR_B      4'hB
`define OAG_FRAME_REG    4'hE
`define OAG_STACK_REG    4'hF
`define OAG_INTDIS_W     14
`define OAG_PF_BAD_MODE  2'h3
`define OAG_PF_NO_STEP   2'h0
`define OAG_PF_SEL_2     2'h1
`define OAG_PF_SEL_4     2'h2
`define OAG_PF_SEL_6     2'h3
`define OAG_STEP_2       16'h0002
`define OAG_STEP_4       16'h0004
`define OAG_STEP_6       16'h0006
`define OAG_STEP_DFLT    16'h0002
`endif

/* common/oag_pkg.sv */
package oag_pkg;
    typedef enum logic [2:0] {
        OAG_M_FILE     = 3'h0,
        OAG_M_DIRECT   = 3'h1,
        OAG_M_IND      = 3'h2,
        OAG_M_POST     = 3'h3,
        OAG_M_PRE      = 3'h4,
        OAG_M_INDEXED  = 3'h5,
        OAG_M_LITOFS   = 3'h6
    } oag_mode_t;
    typedef enum logic [2:0] {
        OAG_C_GENERAL  = 3'h0,
        OAG_C_MOVE     = 3'h1,
        OAG_C_ACCUM    = 3'h2,
        OAG_C_PREFETCH = 3'h3,
        OAG_C_BRANCH   = 3'h4,
        OAG_C_INTDIS   = 3'h5,
        OAG_C_UNLINK   = 3'h6,
        OAG_C_NOP      = 3'h7
    } oag_class_t;
    typedef enum logic [1:0] {
        OAG_PM_IND     = 2'h0,
        OAG_PM_INDEXED = 2'h1,
        OAG_PM_POST    = 2'h2
    } oag_pmode_t;
endpackage : oag_pkg

/* verif/oag_top_bench.sv */
`timescale 1ns/1ps
module oag_top_bench;
    import oag_pkg::*;
    localparam int W = 16;
    ////////////////////////////////////////////////////////////////////////////////
    logic           MCLK      = 1'b0;
    logic           RESET_N   = 1'b0;
    logic           ISSUE     = 1'b0;
    oag_class_t     ICLASS    = OAG_C_NOP;
    oag_mode_t      SRC_MODE  = OAG_M_FILE;
    oag_mode_t      DST_MODE  = OAG_M_FILE;
    logic [3:0]     SRC_REG   = 4'h0;
    logic [3:0]     DST_REG   = 4'h0;
    logic [3:0]     OFS_REG   = 4'h0;
    logic [W-1:0]   ADDR_FIELD = 16'h0000;
    logic [W-1:0]   LIT_FIELD = 16'h0000;
    logic [W-1:0]   STEP      = 16'h0000;
    logic [3:0]     XPF_REG   = 4'h8;
    logic [3:0]     YPF_REG   = 4'hA;
    oag_pmode_t     XPF_MODE  = OAG_PM_IND;
    oag_pmode_t     YPF_MODE  = OAG_PM_IND;
    logic [1:0]     XPF_STEP  = 2'h1;
    logic [1:0]     YPF_STEP  = 2'h1;
    logic [W*16-1:0] WREG_FLAT;
    logic           DONE, ILLEGAL, WB_A_EN, WB_B_EN;
    logic [W-1:0]   SRC_EA, DST_EA, X_EA, Y_EA, LIT_OUT, WB_A_VAL, WB_B_VAL;
    logic [3:0]     WB_A_REG, WB_B_REG;
    int             fails      = 0;
    int             n_compared = 0;
    oag_pmode_t     bm [5] = '{OAG_PM_IND, OAG_PM_INDEXED, OAG_PM_IND,
                               oag_pmode_t'(2'h3), OAG_PM_POST};
    logic [3:0]     bx [5] = '{4'h7, 4'h8, 4'hA, 4'h9, 4'h8};
    ////////////////////////////////////////////////////////////////////////////////
    oag_top #(.W(W)) dut_u (.MCLK(MCLK), .RESET_N(RESET_N), .ISSUE(ISSUE), .ICLASS(ICLASS),
        .SRC_MODE(SRC_MODE), .DST_MODE(DST_MODE), .SRC_REG(SRC_REG), .DST_REG(DST_REG),
        .OFS_REG(OFS_REG), .ADDR_FIELD(ADDR_FIELD), .LIT_FIELD(LIT_FIELD), .STEP(STEP),
        .XPF_REG(XPF_REG), .YPF_REG(YPF_REG), .XPF_MODE(XPF_MODE), .YPF_MODE(YPF_MODE),
        .XPF_STEP(XPF_STEP), .YPF_STEP(YPF_STEP), .WREG_FLAT(WREG_FLAT), .DONE(DONE),
        .ILLEGAL(ILLEGAL), .SRC_EA(SRC_EA), .DST_EA(DST_EA), .X_EA(X_EA), .Y_EA(Y_EA),
        .LIT_OUT(LIT_OUT), .WB_A_EN(WB_A_EN), .WB_A_REG(WB_A_REG), .WB_A_VAL(WB_A_VAL),
        .WB_B_EN(WB_B_EN), .WB_B_REG(WB_B_REG), .WB_B_VAL(WB_B_VAL));
    always #25 MCLK = ~MCLK;
    ////////////////////////////////////////////////////////////////////////////////
    // working register contents, all distinct and even
    function automatic logic [W-1:0] wv(input int i);
        wv = 16'h1000 + 16'(i * 258);
    endfunction : wv
    task automatic chk(input string nm, input logic [W-1:0] seen, input logic [W-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // issue on the current falling edge, check after the answering edge
    task automatic fire;
        ISSUE = 1'b1;
        @(posedge MCLK);
        @(negedge MCLK);
    endtask : fire
    task automatic idle;
        ISSUE = 1'b0;
        @(negedge MCLK);
    endtask : idle
    task automatic ok_wb(input logic a, input logic b);
        chk("done", DONE, 16'h0001);
        chk("illegal", ILLEGAL, 16'h0000);
        chk("wb_a_en", WB_A_EN, a);
        chk("wb_b_en", WB_B_EN, b);
    endtask : ok_wb
    task automatic refused(input string nm);
        chk({nm, "_illegal"}, ILLEGAL, 16'h0001);
        chk({nm, "_done"}, DONE, 16'h0001);
        chk({nm, "_wb"}, {WB_A_EN, WB_B_EN}, 16'h0000);
    endtask : refused
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_move;
        ICLASS = OAG_C_MOVE;
        SRC_MODE = OAG_M_POST;
        SRC_REG = 4'h3;
        STEP = 16'h0002;
        DST_MODE = OAG_M_INDEXED;
        DST_REG = 4'h5;
        OFS_REG = 4'h4;
        fire();
        ok_wb(1'b1, 1'b0);
        chk("post_ea", SRC_EA, wv(3));
        chk("post_reg", WB_A_REG, 16'h0003);
        chk("post_val", WB_A_VAL, wv(3) + 16'h0002);
        chk("mv_idx", DST_EA, wv(5) + wv(4));
        SRC_MODE = OAG_M_PRE;
        SRC_REG = 4'h6;
        STEP = 16'hFFFE;
        DST_MODE = OAG_M_LITOFS;
        DST_REG = 4'h7;
        LIT_FIELD = 16'h0030;
        fire();
        ok_wb(1'b1, 1'b0);
        chk("pre_ea", SRC_EA, wv(6) - 16'h0002);
        chk("pre_val", WB_A_VAL, wv(6) - 16'h0002);
        chk("litofs", DST_EA, wv(7) + 16'h0030);
        SRC_MODE = OAG_M_IND;
        SRC_REG = 4'h1;
        DST_MODE = OAG_M_DIRECT;
        fire();
        ok_wb(1'b0, 1'b0);
        chk("mv_ind", SRC_EA, wv(1));
        chk("mv_dir_dst", DST_EA, 16'h0000);
        SRC_MODE = OAG_M_DIRECT;
        DST_MODE = OAG_M_IND;
        fire();
        refused("mv_dir_src");
        idle();
    endtask : t_move
    task automatic t_general;
        ICLASS = OAG_C_GENERAL;
        SRC_MODE = OAG_M_FILE;
        ADDR_FIELD = 16'h0ABC;
        DST_MODE = OAG_M_IND;
        DST_REG = 4'h2;
        fire();
        ok_wb(1'b0, 1'b0);
        chk("file_ea", SRC_EA, 16'h0ABC);
        chk("ind_ea", DST_EA, wv(2));
        SRC_MODE = OAG_M_INDEXED;
        SRC_REG = 4'h1;
        OFS_REG = 4'h2;
        fire();
        refused("gen_idx");
        ICLASS = OAG_C_ACCUM;
        fire();
        ok_wb(1'b0, 1'b0);
        chk("acc_idx", SRC_EA, wv(1) + wv(2));
        idle();
    endtask : t_general
    task automatic t_prefetch;
        ICLASS = OAG_C_PREFETCH;
        OFS_REG = 4'h4;
        XPF_REG = 4'h9;
        XPF_MODE = OAG_PM_INDEXED;
        YPF_REG = 4'hA;
        YPF_MODE = OAG_PM_POST;
        for (int k = 1; k <= 3; k++) begin
            YPF_STEP = 2'(k);
            fire();
            ok_wb(1'b0, 1'b1);
            chk("x_idx", X_EA, wv(9) + wv(4));
            chk("y_post", Y_EA, wv(10));
            chk("y_reg", WB_B_REG, 16'h000A);
            chk("y_val", WB_B_VAL, wv(10) + 16'(2 * k));
        end
        XPF_REG = 4'h8;
        XPF_MODE = OAG_PM_IND;
        YPF_REG = 4'hB;
        YPF_MODE = OAG_PM_INDEXED;
        fire();
        ok_wb(1'b0, 1'b0);
        chk("x_ind", X_EA, wv(8));
        chk("y_idx", Y_EA, wv(11) + wv(4));
        idle();
    endtask : t_prefetch
    task automatic t_pf_bad;
        YPF_REG = 4'hB;
        YPF_MODE = OAG_PM_IND;
        for (int k = 0; k < 5; k++) begin
            XPF_REG = bx[k];
            XPF_MODE = bm[k];
            XPF_STEP = 2'h0;
            fire();
            refused("pf_bad");
        end
        XPF_REG = 4'h8;
        XPF_MODE = OAG_PM_IND;
        YPF_REG = 4'hA;
        YPF_MODE = OAG_PM_INDEXED;
        fire();
        refused("y_idx_a");
        YPF_REG = 4'hC;
        YPF_MODE = OAG_PM_IND;
        fire();
        refused("y_range");
        idle();
    endtask : t_pf_bad
    task automatic t_other;
        ICLASS = OAG_C_BRANCH;
        LIT_FIELD = 16'h8004;
        fire();
        chk("branch", LIT_OUT, 16'h8004);
        ICLASS = OAG_C_INTDIS;
        LIT_FIELD = 16'hFFFF;
        fire();
        chk("intdis", LIT_OUT, 16'h3FFF);
        ICLASS = OAG_C_UNLINK;
        fire();
        ok_wb(1'b1, 1'b0);
        chk("unlink_ea", SRC_EA, wv(14));
        chk("unlink_reg", WB_A_REG, 16'h000F);
        chk("unlink_val", WB_A_VAL, wv(14));
        ICLASS = OAG_C_NOP;
        fire();
        ok_wb(1'b0, 1'b0);
        idle();
    endtask : t_other
    ////////////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    initial begin
        for (int i = 0; i < 16; i++) begin
            WREG_FLAT[16*i +: 16] = wv(i);
        end
        repeat (16) @(negedge MCLK);
        chk("rst_done", {DONE, ILLEGAL, WB_A_EN, WB_B_EN}, 16'h0000);
        RESET_N = 1'b1;
        t_move();
        t_general();
        t_prefetch();
        t_pf_bad();
        t_other();
        results();
    end
    initial begin
        #(2000 * 50);
        fails++;
        results();
    end
endmodule : oag_top_bench

/* verilog/oag_ea_unit.sv */
`timescale 1ns/1ps
`include "oag_defines.svh"
module oag_ea_unit
    import oag_pkg::*;
#(
    parameter int W = 16
) (
    input  wire oag_pkg::oag_mode_t mode,
    input  wire logic [W-1:0]       field,
    input  wire logic [W-1:0]       base,
    input  wire logic [W-1:0]       offs,
    input  wire logic [W-1:0]       lit,
    input  wire logic [W-1:0]       step,
    output logic                    ok,
    output logic [W-1:0]            ea,
    output logic                    wb_en,
    output logic [W-1:0]            wb_val
);
    always_comb begin
        ok     = 1'b1;
        ea     = '0;
        wb_en  = 1'b0;
        wb_val = base;
        case (mode)
            OAG_M_FILE: begin
                ea = field;
            end
            OAG_M_DIRECT: begin
                ok = 1'b0;
            end
            OAG_M_IND: begin
                ea = base;
            end
            OAG_M_POST: begin
                ea     = base;
                wb_en  = 1'b1;
                wb_val = base + step;
            end
            OAG_M_PRE: begin
                wb_en  = 1'b1;
                wb_val = base + step;
                ea     = base + step;
            end
            OAG_M_INDEXED: begin
                ea = base + offs;
            end
            OAG_M_LITOFS: begin
                ea = base + lit;
            end
            default: begin
                ok = 1'b0;
            end
        endcase
    end
endmodule : oag_ea_unit

/* verilog/oag_top.sv */
`timescale 1ns/1ps
`include "oag_defines.svh"
module oag_top #(
    parameter int W = 16
) (
    input  wire logic                  MCLK,
    input  wire logic                  RESET_N,
    input  wire logic                  ISSUE,
    input  wire oag_pkg::oag_class_t   ICLASS,
    input  wire oag_pkg::oag_mode_t    SRC_MODE,
    input  wire oag_pkg::oag_mode_t    DST_MODE,
    input  wire logic [3:0]            SRC_REG,
    input  wire logic [3:0]            DST_REG,
    input  wire logic [3:0]            OFS_REG,
    input  wire logic [W-1:0]          ADDR_FIELD,
    input  wire logic [W-1:0]          LIT_FIELD,
    input  wire logic [W-1:0]          STEP,
    input  wire logic [3:0]            XPF_REG,
    input  wire logic [3:0]            YPF_REG,
    input  wire oag_pkg::oag_pmode_t   XPF_MODE,
    input  wire oag_pkg::oag_pmode_t   YPF_MODE,
    input  wire logic [1:0]            XPF_STEP,
    input  wire logic [1:0]            YPF_STEP,
    input  wire logic [W*16-1:0]       WREG_FLAT,
    output logic                       DONE,
    output logic                       ILLEGAL,
    output logic [W-1:0]               SRC_EA,
    output logic [W-1:0]               DST_EA,
    output logic [W-1:0]               X_EA,
    output logic [W-1:0]               Y_EA,
    output logic [W-1:0]               LIT_OUT,
    output logic                       WB_A_EN,
    output logic [3:0]                 WB_A_REG,
    output logic [W-1:0]               WB_A_VAL,
    output logic                       WB_B_EN,
    output logic [3:0]                 WB_B_REG,
    output logic [W-1:0]               WB_B_VAL
);
    import oag_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    logic [W-1:0] wreg [`OAG_NREGS];
    always_comb begin
        for (int i = 0; i < `OAG_NREGS; i++) begin
            wreg[i] = WREG_FLAT[i*W +: W];
        end
    end

    oag_mode_t    s_mode, d_mode;
    logic         s_ok, d_ok, s_wb, d_wb;
    logic [W-1:0] s_ea, d_ea, s_wv, d_wv;
    ////////////////////////////////////////////////////////////////////////
    // general operand units
    oag_ea_unit #(.W(W)) u_src (
        .mode   (s_mode),
        .field  (ADDR_FIELD),
        .base   (wreg[SRC_REG]),
        .offs   (wreg[OFS_REG]),
        .lit    (LIT_FIELD),
        .step   (STEP),
        .ok     (s_ok),
        .ea     (s_ea),
        .wb_en  (s_wb),
        .wb_val (s_wv)
    );
    oag_ea_unit #(.W(W)) u_dst (
        .mode   (d_mode),
        .field  (ADDR_FIELD),
        .base   (wreg[DST_REG]),
        .offs   (wreg[OFS_REG]),
        .lit    (LIT_FIELD),
        .step   (STEP),
        .ok     (d_ok),
        .ea     (d_ea),
        .wb_en  (d_wb),
        .wb_val (d_wv)
    );
    ////////////////////////////////////////////////////////////////////////
    // prefetch units
    function automatic logic [W-1:0] pf_step(input logic [1:0] s);
        case (s)
            `OAG_PF_SEL_2: pf_step = W'(`OAG_STEP_2);
            `OAG_PF_SEL_4: pf_step = W'(`OAG_STEP_4);
            `OAG_PF_SEL_6: pf_step = W'(`OAG_STEP_6);
            default: pf_step = '0;
        endcase
    endfunction : pf_step

    logic         x_ok, y_ok, x_wb, y_wb;
    logic [W-1:0] x_ea, y_ea, x_wv, y_wv;
    always_comb begin
        x_ok = (XPF_REG == `OAG_X_PTR_A || XPF_REG == `OAG_X_PTR_B)
             && !(XPF_MODE == OAG_PM_INDEXED && XPF_REG != `OAG_X_PTR_B)
             && !(XPF_MODE == OAG_PM_POST && XPF_STEP == `OAG_PF_NO_STEP)
             && XPF_MODE != `OAG_PF_BAD_MODE;
        y_ok = (YPF_REG == `OAG_Y_PTR_A || YPF_REG == `OAG_Y_PTR_B)
             && !(YPF_MODE == OAG_PM_INDEXED && YPF_REG != `OAG_Y_PTR_B)
             && !(YPF_MODE == OAG_PM_POST && YPF_STEP == `OAG_PF_NO_STEP)
             && YPF_MODE != `OAG_PF_BAD_MODE;
        x_ea = wreg[XPF_REG];
        y_ea = wreg[YPF_REG];
        if (XPF_MODE == OAG_PM_INDEXED) begin
            x_ea = wreg[XPF_REG] + wreg[OFS_REG];
        end
        if (YPF_MODE == OAG_PM_INDEXED) begin
            y_ea = wreg[YPF_REG] + wreg[OFS_REG];
        end
        x_wb = XPF_MODE == OAG_PM_POST;
        y_wb = YPF_MODE == OAG_PM_POST;
        x_wv = wreg[XPF_REG] + pf_step(XPF_STEP);
        y_wv = wreg[YPF_REG] + pf_step(YPF_STEP);
    end
    ////////////////////////////////////////////////////////////////////////
    // class decode
    logic         done_d, ill_d, wa_d, wb_d;
    logic [W-1:0] sea_d, dea_d, xea_d, yea_d, lit_d, wav_d, wbv_d;
    logic [3:0]   war_d, wbr_d;
    logic         done_q, ill_q, wa_q, wb_q;
    logic [W-1:0] sea_q, dea_q, xea_q, yea_q, lit_q, wav_q, wbv_q;
    logic [3:0]   war_q, wbr_q;
    logic         idx_allowed;

    always_comb begin
        idx_allowed = (ICLASS == OAG_C_MOVE) || (ICLASS == OAG_C_ACCUM);
        s_mode = SRC_MODE;
        d_mode = DST_MODE;
        done_d = ISSUE;
        ill_d  = 1'b0;
        sea_d  = '0;
        dea_d  = '0;
        xea_d  = '0;
        yea_d  = '0;
        lit_d  = '0;
        wa_d   = 1'b0;
        war_d  = '0;
        wav_d  = '0;
        wb_d   = 1'b0;
        wbr_d  = '0;
        wbv_d  = '0;
        case (ICLASS)
            OAG_C_GENERAL, OAG_C_MOVE, OAG_C_ACCUM: begin
                ill_d = (!idx_allowed && (SRC_MODE == OAG_M_INDEXED
                        || DST_MODE == OAG_M_INDEXED)) || !s_ok;
                sea_d = s_ea;
                dea_d = d_ok ? d_ea : '0;
                wa_d  = s_wb;
                war_d = SRC_REG;
                wav_d = s_wv;
                wb_d  = d_wb && d_ok;
                wbr_d = DST_REG;
                wbv_d = d_wv;
            end
            OAG_C_PREFETCH: begin
                ill_d = !(x_ok && y_ok);
                xea_d = x_ea;
                yea_d = y_ea;
                wa_d  = x_wb && x_ok;
                war_d = XPF_REG;
                wav_d = x_wv;
                wb_d  = y_wb && y_ok;
                wbr_d = YPF_REG;
                wbv_d = y_wv;
            end
            OAG_C_BRANCH: begin
                lit_d = LIT_FIELD;
            end
            OAG_C_INTDIS: begin
                lit_d = W'(LIT_FIELD[`OAG_INTDIS_W-1:0]);
            end
            OAG_C_UNLINK: begin
                sea_d = wreg[`OAG_FRAME_REG];
                wa_d  = 1'b1;
                war_d = `OAG_STACK_REG;
                wav_d = wreg[`OAG_FRAME_REG];
            end
            OAG_C_NOP: begin
            end
            default: begin
                ill_d = 1'b1;
            end
        endcase
        if (!ISSUE || ill_d) begin
            wa_d = 1'b0;
            wb_d = 1'b0;
        end
        ill_d = ill_d && ISSUE;
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            done_q <= 1'b0;
            ill_q  <= 1'b0;
            sea_q  <= '0;
            dea_q  <= '0;
            xea_q  <= '0;
            yea_q  <= '0;
            lit_q  <= '0;
            wa_q   <= 1'b0;
            war_q  <= '0;
            wav_q  <= '0;
            wb_q   <= 1'b0;
            wbr_q  <= '0;
            wbv_q  <= '0;
        end else begin
            done_q <= done_d;
            ill_q  <= ill_d;
            sea_q  <= sea_d;
            dea_q  <= dea_d;
            xea_q  <= xea_d;
            yea_q  <= yea_d;
            lit_q  <= lit_d;
            wa_q   <= wa_d;
            war_q  <= war_d;
            wav_q  <= wav_d;
            wb_q   <= wb_d;
            wbr_q  <= wbr_d;
            wbv_q  <= wbv_d;
        end
    end

    assign DONE     = done_q;
    assign ILLEGAL  = ill_q;
    assign SRC_EA   = sea_q;
    assign DST_EA   = dea_q;
    assign X_EA     = xea_q;
    assign Y_EA     = yea_q;
    assign LIT_OUT  = lit_q;
    assign WB_A_EN  = wa_q;
    assign WB_A_REG = war_q;
    assign WB_A_VAL = wav_q;
    assign WB_B_EN  = wb_q;
    assign WB_B_REG = wbr_q;
    assign WB_B_VAL = wbv_q;
    ////////////////////////////////////////////////////////////////////////
    // checks
    a_file_addr: assert property (@(posedge MCLK) disable iff (!RESET_N)
        ISSUE && ICLASS == OAG_C_GENERAL && SRC_MODE == OAG_M_FILE
        |=> SRC_EA == $past(ADDR_FIELD)) else $error("file address wrong");
    a_ind_addr: assert property (@(posedge MCLK) disable iff (!RESET_N)
        ISSUE && ICLASS == OAG_C_MOVE && SRC_MODE == OAG_M_IND
        |=> SRC_EA == $past(wreg[SRC_REG]) && !WB_A_EN) else $error("indirect wrong");
    a_post_step: assert property (@(posedge MCLK) disable iff (!RESET_N)
        ISSUE && ICLASS == OAG_C_MOVE && SRC_MODE == OAG_M_POST
        |=> WB_A_EN && WB_A_VAL == SRC_EA + $past(STEP)) else $error("post step wrong");
    a_pre_step: assert property (@(posedge MCLK) disable iff (!RESET_N)
        ISSUE && ICLASS == OAG_C_MOVE && SRC_MODE == OAG_M_PRE
        |=> WB_A_EN && WB_A_VAL == SRC_EA) else $error("pre step wrong");
    a_idx_class: assert property (@(posedge MCLK) disable iff (!RESET_N)
        ISSUE && ICLASS == OAG_C_GENERAL && SRC_MODE == OAG_M_INDEXED
        |=> ILLEGAL && !WB_A_EN) else $error("indexed not refused");
    a_pf_space: assert property (@(posedge MCLK) disable iff (!RESET_N)
        ISSUE && ICLASS == OAG_C_PREFETCH && (XPF_REG < `OAG_X_PTR_A
        || XPF_REG > `OAG_X_PTR_B) |=> ILLEGAL) else $error("x pointer not refused");
    a_pf_indexed: assert property (@(posedge MCLK) disable iff (!RESET_N)
        ISSUE && ICLASS == OAG_C_PREFETCH && YPF_MODE == OAG_PM_INDEXED
        && YPF_REG == `OAG_Y_PTR_A |=> ILLEGAL) else $error("y indexed not refused");
    a_intdis_lit: assert property (@(posedge MCLK) disable iff (!RESET_N)
        ISSUE && ICLASS == OAG_C_INTDIS |=> LIT_OUT[W-1:`OAG_INTDIS_W] == '0
        && DONE) else $error("disable literal too wide");
endmodule : oag_top
